// [src/irq_unit_consts.vh]
// constants of the interrupt and event-reporting unit
// included by the unit's top design file only, not by its synchroniser or picker; definitions only
`ifndef IRQ_UNIT_CONSTS_VH
`define IRQ_UNIT_CONSTS_VH

`define CLK_PERIOD_NS 50
`define SELFTEST_NS 1000
`define SELFTEST_CYC ((`SELFTEST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_STABLE_US 200

`define BIT_SETUP 7
`define BIT_CBUF 6
`define BIT_FLAGS 5
`define BIT_ENUM 2
`define BIT_BUSACT 1
`define BIT_READY 0

`define MASK_RESET 8'hE7
`define MASK_VALID 8'hE7
`define BYTE_ZERO 8'h00

`define ADDR_COMMAND 3'h4

`endif

// [src/sync_2ff.v]
// two-stage synchroniser for a group of level signals
// assumes each bit is quasi-static relative to ref_clk
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= INIT;
         sync_out <= INIT;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // sync_2ff
`default_nettype wire

// [src/prio_pick.v]
// picks the highest set bit of a request vector as a one-hot word
// purely combinational, same clock domain as its user
`timescale 1ns/1ps
`default_nettype none
module prio_pick #(
   parameter WIDTH = 8
) (
   input wire [WIDTH-1:0] req,
   output reg [WIDTH-1:0] grant
);
   integer i;
   reg found;

   always @* begin
      grant = {WIDTH{1'b0}};
      found = 1'b0;
      for (i = WIDTH - 1; i >= 0; i = i - 1) begin
         if (req[i] && !found) begin
            grant[i] = 1'b1;
            found = 1'b1;
         end
      end
   end
endmodule // prio_pick
`default_nettype wire

// [src/usb_bridge_interrupt_unit.v]
// interrupt and event-reporting unit of a usb peripheral bridge
// assumes event inputs come from core logic on ref_clk; master pins are async
// Operation
// [R1] six sources, each gated by its mask bit
// [R2] enabled event drops request pin, sets bit
// [R3] status byte read on low lanes clears
// [R4] one request shown, others queued
// [R5] register read holds interrupts until data read
// [R6] unhandled setup packet sets bit 7
// [R7] control buffer available sets bit 6
// [R8] any out fifo empty change sets bit 5
// [R9] set configuration sets bit 2
// [R10] bus activity stop or resume sets bit 1
// [R11] self-test done or wake sets bit 0
// [R12] valid eeprom: enumeration interrupt replaces ready
// [R13] master waits for ready before access
// [R14] bus-powered suspend: master orders low power
// [R15] pending status shown on read, ready low
// [R16] master samples ready when request asserts
// [R17] usb bus reset: re-enumerate, then bit 2
// [R18] master reconfigures and flushes after re-enumeration
// [R19] resume or wake pin leaves low power
// [R20] reset held until clock stable 200 us
// [R21] highest bit first, pin released per read
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_consts.vh"
module usb_bridge_interrupt_unit #(
   parameter NUM_OUT_FIFO = 2,
   parameter SELFTEST_CYCLES = `SELFTEST_CYC
) (
   input wire ref_clk,
   input wire reset_n,
   input wire eeprom_desc_valid,
   input wire setup_evt,
   input wire ctrl_buf_evt,
   input wire [NUM_OUT_FIFO-1:0] out_fifo_empty,
   input wire set_config_evt,
   input wire usb_bus_reset,
   input wire link_idle,
   input wire low_power_req,
   input wire mask_wr,
   input wire [7:0] mask_wdata,
   input wire reg_read_start,
   input wire reg_rdata_valid,
   input wire [7:0] reg_rdata,
   input wire wake_pin,
   input wire read_strobe_n,
   input wire bus_drive_enable_n,
   input wire [2:0] fifo_addr,
   output reg irq_request_n,
   output reg ready_pin,
   output reg [7:0] fifo_data_bus_out,
   output reg fifo_data_bus_oe_n,
   output reg [7:0] irq_mask_reg,
   output reg low_power,
   output reg enumeration_done
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_STATUS = 3'b010;
   localparam [2:0] ST_DATA = 3'b100;
   localparam [31:0] ST_CYC_FULL = SELFTEST_CYCLES;
   localparam [15:0] ST_CYC = ST_CYC_FULL[15:0];

   reg [1:0] rst_sync_q;
   wire rst_n = rst_sync_q[1];

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   // master pins through two flops each
   wire [5:0] pins_s;
   sync_2ff #(.WIDTH(6), .INIT(6'h00)) u_pin_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .async_in({wake_pin, ~read_strobe_n, ~bus_drive_enable_n, fifo_addr}),
      .sync_out(pins_s)
   );
   wire wake_s = pins_s[5];
   wire rd_s = pins_s[4];
   wire oe_s = pins_s[3];
   wire cmd_s = (pins_s[2:0] == `ADDR_COMMAND);

   reg rd_prev_q;
   reg rd_cmd_q;
   reg wake_prev_q;
   reg idle_prev_q;
   reg [NUM_OUT_FIFO-1:0] empty_prev_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [7:0] pend_q;
   reg [7:0] cause_q;
   reg [7:0] data_q;
   reg hold_q;
   reg data_avail_q;
   reg eeprom_q;
   reg st_done_q;
   reg [15:0] st_cnt_q;

   wire rd_release = rd_prev_q && !rd_s && rd_cmd_q;
   wire wake_rise = wake_s && !wake_prev_q;
   wire st_fire = !st_done_q && (st_cnt_q == ST_CYC);
   wire fifo_change = |(out_fifo_empty ^ empty_prev_q);
   wire idle_change = link_idle ^ idle_prev_q;

   // raw events by status bit
   reg [7:0] ev;
   always @* begin
      ev = `BYTE_ZERO;
      ev[`BIT_SETUP] = setup_evt; // R6
      ev[`BIT_CBUF] = ctrl_buf_evt; // R7
      ev[`BIT_FLAGS] = fifo_change; // R8
      ev[`BIT_ENUM] = set_config_evt || (st_fire && eeprom_q); // R9 R12 R17
      ev[`BIT_BUSACT] = idle_change; // R10 R19
      ev[`BIT_READY] = (st_fire && !eeprom_q) || (low_power && wake_rise); // R11 R12 R19
   end

   wire [7:0] pick;
   prio_pick #(.WIDTH(8)) u_pick (
      .req(pend_q),
      .grant(pick)
   );

   wire take = (state_q == ST_IDLE) && !hold_q && (|pend_q); // R4 R5 R21

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (data_avail_q) begin
               state_d = ST_DATA;
            end else if (take) begin
               state_d = ST_STATUS;
            end
         end
         ST_STATUS: begin
            if (rd_release) begin
               state_d = ST_IDLE; // R3
            end
         end
         ST_DATA: begin
            if (rd_release) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // strobe history; address caught while the strobe is low,
   // since a master may drop it together with the strobe
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_prev_q <= 1'b0;
         rd_cmd_q <= 1'b0;
      end else begin
         rd_prev_q <= rd_s;
         if (rd_s) begin
            rd_cmd_q <= cmd_s;
         end
      end
   end

   // event history for edge detection
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_prev_q <= 1'b0;
         idle_prev_q <= 1'b0;
         empty_prev_q <= {NUM_OUT_FIFO{1'b1}};
      end else begin
         wake_prev_q <= wake_s;
         idle_prev_q <= link_idle;
         empty_prev_q <= out_fifo_empty;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // self-test counter
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_done_q <= 1'b0;
         st_cnt_q <= 16'h0000;
      end else begin
         if (!st_done_q) begin
            st_cnt_q <= st_cnt_q + 16'h0001;
         end
         if (st_fire) begin
            st_done_q <= 1'b1; // R11
         end
      end
   end

   // strap caught while self-test runs
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         eeprom_q <= 1'b0;
      end else if (!st_done_q) begin
         eeprom_q <= eeprom_desc_valid; // R12
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_reg <= `MASK_RESET;
      end else begin
         if (mask_wr) begin
            irq_mask_reg <= mask_wdata & `MASK_VALID;
         end
      end
   end

   // new events set after the take clears, so a set wins
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= `BYTE_ZERO;
      end else begin
         pend_q <= (pend_q & ~(take ? pick : `BYTE_ZERO)) | (ev & irq_mask_reg); // R1 R2
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_request_n <= 1'b1;
      end else begin
         if (take) begin
            irq_request_n <= 1'b0; // R2
         end else if (state_q == ST_IDLE && data_avail_q) begin
            irq_request_n <= 1'b0; // R5
         end else if (rd_release && state_q != ST_IDLE) begin
            irq_request_n <= 1'b1; // R3 R21
         end
      end
   end

   // cause of the offered request, cleared by its read
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_q <= `BYTE_ZERO;
      end else begin
         if (take) begin
            cause_q <= pick; // R21
         end else if (rd_release && state_q == ST_STATUS) begin
            cause_q <= `BYTE_ZERO; // R3
         end
      end
   end

   // read request holds interrupts until its data is read
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= 1'b0;
      end else begin
         if (reg_read_start) begin
            hold_q <= 1'b1; // R5
         end else if (rd_release && state_q == ST_DATA) begin
            hold_q <= 1'b0;
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_avail_q <= 1'b0;
      end else begin
         if (hold_q && reg_rdata_valid && !data_avail_q) begin
            data_avail_q <= 1'b1;
         end else if (state_q == ST_IDLE && data_avail_q) begin
            data_avail_q <= 1'b0;
         end
      end
   end

   // register data kept until the master fetches it
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= `BYTE_ZERO;
      end else begin
         if (hold_q && reg_rdata_valid && !data_avail_q) begin
            data_q <= reg_rdata;
         end
      end
   end

   // ready low while a status byte is offered
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_pin <= 1'b0;
      end else begin
         ready_pin <= st_done_q && !low_power && (state_d != ST_STATUS); // R15
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_data_bus_out <= `BYTE_ZERO;
      end else begin
         if (state_q == ST_DATA) begin
            fifo_data_bus_out <= data_q; // R15
         end else if (state_q == ST_STATUS) begin
            fifo_data_bus_out <= cause_q; // R3 R15
         end else begin
            fifo_data_bus_out <= `BYTE_ZERO;
         end
      end
   end

   // drive only while the command port is selected
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_data_bus_oe_n <= 1'b1;
      end else begin
         fifo_data_bus_oe_n <= !(oe_s && cmd_s);
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_power <= 1'b0;
      end else begin
         if (low_power_req) begin
            low_power <= 1'b1;
         end else if (low_power && (wake_rise || (idle_prev_q && !link_idle))) begin
            low_power <= 1'b0; // R19
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         enumeration_done <= 1'b0;
      end else begin
         if (usb_bus_reset) begin
            enumeration_done <= 1'b0; // R17
         end else if (set_config_evt) begin
            enumeration_done <= 1'b1; // R9
         end
      end
   end
endmodule // usb_bridge_interrupt_unit
`default_nettype wire

// [verification/irq_unit_checker.sv]
// concurrent checks on the interrupt unit's ports
// assumes one clock domain, ref_clk, and the chip reset reset_n
`timescale 1ns/1ps
`default_nettype none
module irq_unit_checker (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic set_config_evt,
   input wire logic usb_bus_reset,
   input wire logic low_power_req,
   input wire logic mask_wr,
   input wire logic [7:0] mask_wdata,
   input wire logic wake_pin,
   input wire logic read_strobe_n,
   input wire logic bus_drive_enable_n,
   input wire logic [2:0] fifo_addr,
   input wire logic irq_request_n,
   input wire logic ready_pin,
   input wire logic [7:0] fifo_data_bus_out,
   input wire logic fifo_data_bus_oe_n,
   input wire logic [7:0] irq_mask_reg,
   input wire logic low_power,
   input wire logic enumeration_done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence rel_s;
      $rose(read_strobe_n) ##0 $past(fifo_addr) == 3'h4;
   endsequence
   sequence status_s;
      !irq_request_n && !ready_pin && !fifo_data_bus_oe_n;
   endsequence
   a_mask_bits_fixed: assert property (irq_mask_reg[4:3] == 2'b00)
      else $error("mask bits 4:3 set");
   a_mask_write_lands: assert property (mask_wr |=> irq_mask_reg == ($past(mask_wdata) & 8'hE7))
      else $error("mask write lost");
   a_drive_after_strobe: assert property ($fell(fifo_data_bus_oe_n) |-> !$past(bus_drive_enable_n, 3))
      else $error("bus driven unasked");
   a_status_one_hot: assert property (status_s |-> $onehot(fifo_data_bus_out))
      else $error("status not one-hot");
   a_release_clears: assert property (!irq_request_n ##0 rel_s |-> ##[1:4] irq_request_n)
      else $error("request held after read");
   a_low_power_entry: assert property (low_power_req |-> ##[1:2] low_power)
      else $error("no low power");
   a_wake_exits: assert property ($rose(wake_pin) && low_power |-> ##[1:6] !low_power)
      else $error("wake ignored");
   a_bus_reset_enum: assert property (usb_bus_reset |-> ##[1:2] !enumeration_done)
      else $error("enumeration kept");
   a_config_enum: assert property (set_config_evt && !usb_bus_reset |-> ##[1:3] enumeration_done)
      else $error("enumeration not set");
endmodule // irq_unit_checker
bind usb_bridge_interrupt_unit irq_unit_checker chk_i (.ref_clk, .reset_n, .set_config_evt,
   .usb_bus_reset, .low_power_req, .mask_wr, .mask_wdata, .wake_pin, .read_strobe_n,
   .bus_drive_enable_n, .fifo_addr, .irq_request_n, .ready_pin, .fifo_data_bus_out,
   .fifo_data_bus_oe_n, .irq_mask_reg, .low_power, .enumeration_done);
`default_nettype wire

// [verification/bridge_master.sv]
// model of the external master reading the command port
// assumes ref_clk from the bench; pins change on falling edges
`timescale 1ns/1ps
`default_nettype none
module bridge_master (
   input wire logic ref_clk,
   input wire logic oe_n,
   input wire logic [7:0] bus,
   input wire logic ready_pin,
   output logic read_strobe_n,
   output logic bus_drive_enable_n,
   output logic [2:0] fifo_addr
);
   initial begin
      {read_strobe_n, bus_drive_enable_n, fifo_addr} = 5'h18;
   end
   task automatic rd(output logic [7:0] d, output logic r);
      int i;
      r = ready_pin;
      @(negedge ref_clk);
      {read_strobe_n, bus_drive_enable_n, fifo_addr} = 5'h04;
      for (i = 0; i < 8 && oe_n !== 1'b0; i++) @(posedge ref_clk);
      @(posedge ref_clk);
      d = bus;
      @(negedge ref_clk);
      {read_strobe_n, bus_drive_enable_n, fifo_addr} = 5'h18;
      repeat (4) @(negedge ref_clk);
   endtask
endmodule // bridge_master
`default_nettype wire

// [verification/usb_bridge_interrupt_unit_bench.sv]
// self-checking bench for the interrupt unit with a model master
// assumes a 20 MHz ref_clk; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module usb_bridge_interrupt_unit_bench;
   logic ref_clk = 1'b0, reset_n = 1'b0, link_idle = 1'b0, wake_pin = 1'b0, mask_wr = 1'b0;
   logic usb_bus_reset = 1'b0, low_power_req = 1'b0, reg_read_start = 1'b0, reg_rdata_valid = 1'b0;
   logic [2:0] ev = 3'h0;
   logic eeprom = 1'b0;
   logic [1:0] out_fifo_empty = 2'h3;
   logic [7:0] mask_wdata = 8'h00, reg_rdata = 8'h5A, d, dob, irq_mask_reg;
   logic rsn, oen, oe_n, irq_n, rdy, low_power, enumeration_done, r;
   logic [2:0] fa;
   logic [7:0] exp_t [0:4] = '{8'h80, 8'h40, 8'h04, 8'h20, 8'h02};
   int miscompares = 0, comparisons = 0, i, j;
   always #25 ref_clk = ~ref_clk;
   usb_bridge_interrupt_unit #(.SELFTEST_CYCLES(4)) dut (.ref_clk, .reset_n,
      .eeprom_desc_valid(eeprom), .setup_evt(ev[0]), .ctrl_buf_evt(ev[1]), .out_fifo_empty,
      .set_config_evt(ev[2]), .usb_bus_reset, .link_idle, .low_power_req, .mask_wr,
      .mask_wdata, .reg_read_start, .reg_rdata_valid, .reg_rdata, .wake_pin,
      .read_strobe_n(rsn), .bus_drive_enable_n(oen), .fifo_addr(fa), .irq_request_n(irq_n),
      .ready_pin(rdy), .fifo_data_bus_out(dob), .fifo_data_bus_oe_n(oe_n), .irq_mask_reg,
      .low_power, .enumeration_done);
   bridge_master m (.ref_clk, .oe_n, .bus(dob), .ready_pin(rdy), .read_strobe_n(rsn),
      .bus_drive_enable_n(oen), .fifo_addr(fa));
   task finish_test;
      if (miscompares == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task rdc(input logic [7:0] e, input logic er);
      for (i = 0; i < 80 && irq_n !== 1'b0; i++) @(posedge ref_clk);
      if (i == 80) begin
         miscompares++;
         finish_test;
      end
      m.rd(d, r);
      chk(d, e);
      chk({7'h0, r}, {7'h0, er});
   endtask
   task pulse(input int k);
      @(negedge ref_clk);
      case (k)
         3: out_fifo_empty[0] = ~out_fifo_empty[0];
         4: link_idle = ~link_idle;
         5: usb_bus_reset = 1'b1;
         6: low_power_req = 1'b1;
         7: reg_read_start = 1'b1;
         8: reg_rdata_valid = 1'b1;
         9: mask_wr = 1'b1;
         default: ev[k] = 1'b1;
      endcase
      @(negedge ref_clk);
      {ev, usb_bus_reset, low_power_req, reg_read_start, reg_rdata_valid, mask_wr} = '0;
   endtask
   initial begin
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      rdc(8'h01, 1'b0);
      chk({7'h0, rdy}, 8'h01);
      pulse(5);
      for (j = 0; j < 5; j++) begin
         pulse(j);
         rdc(exp_t[j], 1'b0);
      end
      chk({7'h0, enumeration_done}, 8'h01);
      mask_wdata = 8'hFF;
      pulse(9);
      chk(irq_mask_reg, 8'hE7);
      mask_wdata = 8'h00;
      pulse(9);
      pulse(0);
      repeat (8) @(negedge ref_clk);
      chk({7'h0, irq_n}, 8'h01);
      mask_wdata = 8'hE7;
      pulse(9);
      @(negedge ref_clk);
      ev = 3'h3;
      @(negedge ref_clk);
      ev = 3'h0;
      rdc(8'h80, 1'b0);
      rdc(8'h40, 1'b0);
      chk({7'h0, irq_n}, 8'h01);
      pulse(7);
      pulse(0);
      pulse(8);
      rdc(8'h5A, 1'b1);
      rdc(8'h80, 1'b0);
      pulse(0);
      repeat (6) @(negedge ref_clk);
      pulse(7);
      pulse(8);
      rdc(8'h80, 1'b0);
      rdc(8'h5A, 1'b1);
      pulse(6);
      chk({7'h0, low_power}, 8'h01);
      pulse(4);
      rdc(8'h02, 1'b0);
      pulse(6);
      wake_pin = 1'b1;
      rdc(8'h01, 1'b0);
      chk({7'h0, low_power}, 8'h00);
      @(negedge ref_clk);
      reset_n = 1'b0;
      eeprom = 1'b1;
      out_fifo_empty = 2'h3;
      wake_pin = 1'b0;
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      rdc(8'h04, 1'b0);
      finish_test;
   end
endmodule // usb_bridge_interrupt_unit_bench
`default_nettype wire
